// ---- hw/light_pkg.sv ----
package light_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0] ADDR_POWER    = 8'h00;
  localparam logic [7:0] ADDR_RESET    = 8'h01;
  localparam logic [7:0] ADDR_INTEG    = 8'h02;
  localparam logic [7:0] ADDR_ISEL     = 8'h03;
  localparam logic [7:0] ADDR_THR_LO   = 8'h04;
  localparam logic [7:0] ADDR_THR_HI   = 8'h05;
  localparam logic [7:0] ADDR_COUNT_LO = 8'h06;
  localparam logic [7:0] ADDR_COUNT_HI = 8'h07;
  localparam logic [7:0] ADDR_ID_LO    = 8'h08;
  localparam logic [7:0] ADDR_ID_HI    = 8'h09;
  localparam int         NUM_REGS      = 10;

  // ************************************************************
  // Reset values and codes
  // ************************************************************
  localparam logic [7:0]  POWER_DEF  = 8'h08;
  localparam logic [7:0]  RESET_DEF  = 8'h00;
  localparam logic [7:0]  INTEG_DEF  = 8'h02;
  localparam logic [7:0]  ISEL_DEF   = 8'h03;
  localparam logic [7:0]  THR_LO_DEF = 8'h00;
  localparam logic [7:0]  THR_HI_DEF = 8'h08;
  localparam logic [7:0]  POWER_DOWN = 8'h00;
  localparam logic [7:0]  POWER_ON   = 8'h08;
  localparam logic [7:0]  POWER_TOP  = 8'h0b;
  localparam int          POWER_BIT  = 3;
  localparam logic [7:0]  RESET_CMD  = 8'h10;
  localparam logic [7:0]  INTEG_MAX  = 8'h07;
  localparam logic [7:0]  ISEL_LH    = 8'h01;
  localparam logic [7:0]  ISEL_HL    = 8'h02;
  localparam logic [7:0]  ISEL_OFF   = 8'h03;
  localparam logic [1:0]  TEST_A     = 2'h2;
  localparam logic [1:0]  TEST_B     = 2'h3;
  localparam logic [15:0] FIXED_A    = 16'h5555;
  localparam logic [15:0] FIXED_B    = 16'haaaa;
  // Arbitrary identity value
  localparam logic [15:0] DEVICE_ID_DEF = 16'h00a5;

  // ************************************************************
  // Link framing
  // ************************************************************
  localparam logic [6:0] SLAVE_ADDR = 7'h39;
  localparam logic [3:0] LAST_BIT   = 4'h7;
  localparam logic [3:0] ACK_SLOT   = 4'h8;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam real         CLK_PERIOD_NS = 10.0;
  localparam real         INTEG_MIN_MS  = 6.25;
  localparam int unsigned INTEG_MIN_CYC = $rtoi(INTEG_MIN_MS * 1.0e6 / CLK_PERIOD_NS);

  typedef enum logic [2:0] {LS_IDLE, LS_ADDR, LS_REG, LS_WDATA, LS_RDATA} link_state_t;

endpackage

// ---- hw/light_meas_if.sv ----
`timescale 1ns/1ps
interface light_meas_if;
  logic        power_on;
  logic [2:0]  time_code;
  logic [1:0]  test_sel;
  logic        clear;
  logic [15:0] level;
  logic [15:0] count;
  logic        done;
  modport ctl (output power_on, time_code, test_sel, clear, level, input count, done);
  modport eng (input power_on, time_code, test_sel, clear, level, output count, done);
endinterface

// ---- hw/light_sync.sv ----
`timescale 1ns/1ps
module light_sync
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             i_clk,
  input  wire logic             i_rstn,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] stage1_q;
  logic [WIDTH-1:0] stage2_q;

  // First stage feeds only the second
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      stage1_q <= '0;
      stage2_q <= '0;
    end
    else
    begin
      stage1_q <= i_async;
      stage2_q <= stage1_q;
    end
  end

  assign o_sync = stage2_q;

endmodule

// ---- hw/light_meter.sv ----
`timescale 1ns/1ps
module light_meter
#(
  parameter int unsigned BASE_CYC = light_pkg::INTEG_MIN_CYC
)
(
  input  wire logic   i_clk,
  input  wire logic   i_rstn,
  light_meas_if.eng   m
);

  logic [31:0] cnt_q;
  logic [31:0] period;
  logic [15:0] sample;
  logic        last;
  logic [15:0] count_q;
  logic        done_q;

  // Longest code 0 is 128 times the shortest period
  assign period = 32'(BASE_CYC) << (3'h7 - m.time_code);
  assign last   = (cnt_q >= period - 32'h1);
  assign sample = (m.test_sel == light_pkg::TEST_A) ? light_pkg::FIXED_A :
                  (m.test_sel == light_pkg::TEST_B) ? light_pkg::FIXED_B : m.level;

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn || m.clear)
    begin
      cnt_q   <= 32'h0;
      count_q <= 16'h0;
    end
    else if (m.power_on)
    begin
      cnt_q   <= last ? 32'h0 : cnt_q + 32'h1;
      count_q <= last ? sample : count_q;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
      done_q <= 1'b0;
    else
      done_q <= m.power_on && !m.clear && last;
  end

  assign m.count = count_q;
  assign m.done  = done_q;

  property p_meas_update;
    @(posedge i_clk) disable iff (!i_rstn)
    (m.power_on && !m.clear && last) |=> (done_q && count_q == $past(sample));
  endproperty
  a_meas_update: assert property (p_meas_update)
    else $error("Finished integration did not publish its count");

  property p_meas_hold;
    @(posedge i_clk) disable iff (!i_rstn)
    (!m.power_on && !m.clear) |=> $stable(count_q);
  endproperty
  a_meas_hold: assert property (p_meas_hold)
    else $error("Count changed while powered down");

endmodule

// ---- hw/light_sensor_i2c_slave.sv ----
`timescale 1ns/1ps
// What this block does
// - Act as two-wire slave with single and block register reads and writes.
// - Bytes are eight bits, each followed by an acknowledge from the receiver.
// - Every byte travels most significant bit first, both directions.
// - Write opens with start, address 0x39 and write bit; device acknowledges.
// - Next byte is register address; acknowledged and loaded into the pointer.
// - Each written data byte is acknowledged, stored, then pointer advances.
// - Writes to read-only registers move the pointer but change no contents.
// - Address 0x39 with read bit is acknowledged, then pointed register is sent.
// - Master acknowledge on a read byte makes device send the next register.
// - Light measurement is a sixteen-bit unsigned count readable over the link.
// - Interrupt pulls low while the light count is above the threshold in select 10, at or below it in 01.
// - Powered on, device measures continuously and keeps the latest count.
// - Power-down stops measuring, releases interrupt, keeps all registers.
// - Link stays alive in power-down to accept writes, including power on.
// - Power register 0x00 powers down, 0x08 powers on.
// - Interrupt select: 01 low-to-high, 10 high-to-low, 11 held high.
// - Undefined codes written to registers 0x00 to 0x03 store the default.
// - Reset register 0x10 then stop clears count, restarts; others untouched.
module light_sensor_i2c_slave
#(
  parameter int unsigned P_INTEG_BASE_CYC = light_pkg::INTEG_MIN_CYC,
  parameter logic [15:0] P_DEVICE_ID      = light_pkg::DEVICE_ID_DEF
)
(
  input  wire logic        I_SYS_CLK,
  input  wire logic        I_RSTN,
  input  wire logic        I_SCL,
  input  wire logic        I_SDA_I,
  input  wire logic [15:0] I_LIGHT_LEVEL,
  output logic             O_SDA_O,
  output logic             O_SDA_OE,
  output logic             O_INT_O,
  output logic             O_INT_OE,
  output logic             O_POWER_ON
);

  // ************************************************************
  // Declarations
  // ************************************************************
  light_pkg::link_state_t state_q;
  light_pkg::link_state_t state_d;
  logic        link_clr_q;
  logic        start_tgl_q;
  logic        stop_tgl_q;
  logic        seen_q;
  logic [3:0]  bit_q;
  logic [6:0]  rx_q;
  logic        rd_q;
  logic [7:0]  ptr_q;
  logic        wr_tgl_q;
  logic [7:0]  wr_addr_q;
  logic [7:0]  wr_data_q;
  logic        fetch_tgl_q;
  logic [7:0]  fetch_addr_q;
  logic        sda_oe_q;
  logic [7:0]  tx_q;
  logic [7:0]  power_q;
  logic [7:0]  reset_q;
  logic [7:0]  integ_q;
  logic [7:0]  isel_q;
  logic [7:0]  thr_lo_q;
  logic [7:0]  thr_hi_q;
  logic [7:0]  rd_byte_q;
  logic [2:0]  tg_sync;
  logic [2:0]  tg_prev_q;
  logic        int_oe_q;
  logic        power_on_q;
  logic [7:0]  reg_view [light_pkg::NUM_REGS];
  wire  [7:0]  rx_byte   = {rx_q, I_SDA_I};
  wire         new_frame = (start_tgl_q != seen_q);
  wire         addr_hit  = (rx_byte[7:1] == light_pkg::SLAVE_ADDR);
  wire         take_byte = !new_frame && state_q != light_pkg::LS_IDLE
                           && bit_q == light_pkg::LAST_BIT;
  wire         ack_slot  = !new_frame && bit_q == light_pkg::ACK_SLOT;
  wire         wr_take   = take_byte && state_q == light_pkg::LS_WDATA;
  wire         rd_open   = take_byte && state_q == light_pkg::LS_ADDR && addr_hit && I_SDA_I;
  wire         m_ack     = ack_slot && state_q == light_pkg::LS_RDATA && !I_SDA_I;
  wire         fetch_req = rd_open || m_ack;
  wire         acking    = state_q inside {light_pkg::LS_ADDR, light_pkg::LS_REG,
                                           light_pkg::LS_WDATA};
  wire  [2:0]  tg_ev     = tg_sync ^ tg_prev_q;
  wire         wr_ev     = tg_ev[0];
  wire         fetch_ev  = tg_ev[1];
  wire         stop_ev   = tg_ev[2];
  wire         soft_rst  = stop_ev && reset_q == light_pkg::RESET_CMD;
  wire         power_on  = power_q[light_pkg::POWER_BIT];
  wire  [15:0] threshold = {thr_hi_q, thr_lo_q};
  wire         above;
  wire         int_oe_d;
  wire  [7:0]  wr_value;
  wire  [7:0]  rd_sel;

  light_meas_if meas ();

  // Replace an undefined code by the register's default
  function automatic logic [7:0] legal_value(input logic [7:0] addr, input logic [7:0] data);
    logic       ok;
    logic [7:0] dflt;
    ok   = 1'b1;
    dflt = data;
    case (addr)
      light_pkg::ADDR_POWER:
      begin
        ok   = data == light_pkg::POWER_DOWN
               || (data >= light_pkg::POWER_ON && data <= light_pkg::POWER_TOP);
        dflt = light_pkg::POWER_DEF;
      end
      light_pkg::ADDR_RESET:
      begin
        ok   = data == light_pkg::RESET_CMD;
        dflt = light_pkg::RESET_DEF;
      end
      light_pkg::ADDR_INTEG:
      begin
        ok   = data <= light_pkg::INTEG_MAX;
        dflt = light_pkg::INTEG_DEF;
      end
      light_pkg::ADDR_ISEL:
      begin
        ok   = data >= light_pkg::ISEL_LH && data <= light_pkg::ISEL_OFF;
        dflt = light_pkg::ISEL_DEF;
      end
      default: ok = 1'b1;
    endcase
    return ok ? data : dflt;
  endfunction

  // ************************************************************
  // Start and stop detectors, clocked by the data line
  // ************************************************************
  // Data may only move under a high clock for start or stop, so these toggles
  // settle long before the next clock edge that reads them.
  always_ff @(negedge I_SDA_I or posedge link_clr_q)
  begin
    if (link_clr_q)
      start_tgl_q <= 1'b0;
    else if (I_SCL)
      start_tgl_q <= ~start_tgl_q;
  end

  always_ff @(posedge I_SDA_I or posedge link_clr_q)
  begin
    if (link_clr_q)
      stop_tgl_q <= 1'b0;
    else if (I_SCL)
      stop_tgl_q <= ~stop_tgl_q;
  end

  // ************************************************************
  // Link receive side, rising link clock
  // ************************************************************
  always_ff @(posedge I_SCL or posedge link_clr_q)
  begin
    if (link_clr_q)
    begin
      bit_q <= 4'h0;
      rx_q  <= 7'h0;
    end
    else
    begin
      bit_q <= new_frame ? 4'h1 : (ack_slot ? 4'h0 : bit_q + 4'h1);
      rx_q  <= {rx_q[5:0], I_SDA_I};
    end
  end

  always_comb
  begin
    state_d = state_q;
    if (new_frame)
      state_d = light_pkg::LS_ADDR;
    else if (take_byte && state_q == light_pkg::LS_ADDR && !addr_hit)
      state_d = light_pkg::LS_IDLE;
    else if (ack_slot)
    begin
      unique case (state_q)
        light_pkg::LS_ADDR:  state_d = rd_q ? light_pkg::LS_RDATA : light_pkg::LS_REG;
        light_pkg::LS_REG:   state_d = light_pkg::LS_WDATA;
        light_pkg::LS_WDATA: state_d = light_pkg::LS_WDATA;
        light_pkg::LS_RDATA: state_d = m_ack ? light_pkg::LS_RDATA : light_pkg::LS_IDLE;
        light_pkg::LS_IDLE:  state_d = light_pkg::LS_IDLE;
      endcase
    end
  end

  always_ff @(posedge I_SCL or posedge link_clr_q)
  begin
    if (link_clr_q)
    begin
      state_q <= light_pkg::LS_IDLE;
      seen_q  <= 1'b0;
      rd_q    <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      seen_q  <= start_tgl_q;
      rd_q    <= (take_byte && state_q == light_pkg::LS_ADDR) ? I_SDA_I : rd_q;
    end
  end

  // Pointer always names the next register to store or fetch
  always_ff @(posedge I_SCL or posedge link_clr_q)
  begin
    if (link_clr_q)
    begin
      ptr_q        <= 8'h00;
      wr_tgl_q     <= 1'b0;
      wr_addr_q    <= 8'h00;
      wr_data_q    <= 8'h00;
      fetch_tgl_q  <= 1'b0;
      fetch_addr_q <= 8'h00;
    end
    else
    begin
      if (take_byte && state_q == light_pkg::LS_REG)
        ptr_q <= rx_byte;
      else if (wr_take || fetch_req)
        ptr_q <= ptr_q + 8'h01;
      if (wr_take)
      begin
        wr_tgl_q  <= ~wr_tgl_q;
        wr_addr_q <= ptr_q;
        wr_data_q <= rx_byte;
      end
      if (fetch_req)
      begin
        fetch_tgl_q  <= ~fetch_tgl_q;
        fetch_addr_q <= ptr_q;
      end
    end
  end

  // ************************************************************
  // Link drive side, falling link clock
  // ************************************************************
  // Fetched byte is read at least half a clock later, well after it has settled.
  always_ff @(negedge I_SCL or posedge link_clr_q)
  begin
    if (link_clr_q)
    begin
      sda_oe_q <= 1'b0;
      tx_q     <= 8'h00;
    end
    else if (bit_q == light_pkg::ACK_SLOT && acking)
      sda_oe_q <= 1'b1;
    else if (state_q == light_pkg::LS_RDATA && bit_q == 4'h0)
    begin
      sda_oe_q <= ~rd_byte_q[7];
      tx_q     <= {rd_byte_q[6:0], 1'b0};
    end
    else if (state_q == light_pkg::LS_RDATA && bit_q < light_pkg::ACK_SLOT)
    begin
      sda_oe_q <= ~tx_q[7];
      tx_q     <= {tx_q[6:0], 1'b0};
    end
    else
      sda_oe_q <= 1'b0;
  end

  // ************************************************************
  // Crossing into the system clock
  // ************************************************************
  light_sync #(.WIDTH(3)) u_sync (
    .i_clk   (I_SYS_CLK),
    .i_rstn  (I_RSTN),
    .i_async ({stop_tgl_q, fetch_tgl_q, wr_tgl_q}),
    .o_sync  (tg_sync)
  );

  always_ff @(posedge I_SYS_CLK)
  begin
    link_clr_q <= !I_RSTN;
    tg_prev_q  <= I_RSTN ? tg_sync : 3'h0;
  end

  // ************************************************************
  // Register file
  // ************************************************************
  assign wr_value = legal_value(wr_addr_q, wr_data_q);

  // Only 0x00..0x05 hold writes, so read-only and unmapped writes just move the pointer.
  always_ff @(posedge I_SYS_CLK)
  begin
    if (!I_RSTN)
    begin
      power_q  <= light_pkg::POWER_DEF;
      integ_q  <= light_pkg::INTEG_DEF;
      isel_q   <= light_pkg::ISEL_DEF;
      thr_lo_q <= light_pkg::THR_LO_DEF;
      thr_hi_q <= light_pkg::THR_HI_DEF;
    end
    else if (wr_ev)
    begin
      case (wr_addr_q)
        light_pkg::ADDR_POWER:  power_q  <= wr_value;
        light_pkg::ADDR_INTEG:  integ_q  <= wr_value;
        light_pkg::ADDR_ISEL:   isel_q   <= wr_value;
        light_pkg::ADDR_THR_LO: thr_lo_q <= wr_data_q;
        light_pkg::ADDR_THR_HI: thr_hi_q <= wr_data_q;
        default:                power_q  <= power_q;
      endcase
    end
  end

  always_ff @(posedge I_SYS_CLK)
  begin
    if (!I_RSTN || soft_rst)
      reset_q <= light_pkg::RESET_DEF;
    else if (wr_ev && wr_addr_q == light_pkg::ADDR_RESET)
      reset_q <= wr_value;
  end

  assign reg_view[0] = power_q;
  assign reg_view[1] = reset_q;
  assign reg_view[2] = integ_q;
  assign reg_view[3] = isel_q;
  assign reg_view[4] = thr_lo_q;
  assign reg_view[5] = thr_hi_q;
  assign reg_view[6] = meas.count[7:0];
  assign reg_view[7] = meas.count[15:8];
  assign reg_view[8] = P_DEVICE_ID[7:0];
  assign reg_view[9] = P_DEVICE_ID[15:8];
  assign rd_sel = (fetch_addr_q < 8'(light_pkg::NUM_REGS)) ? reg_view[fetch_addr_q[3:0]]
                                                            : 8'h00;

  always_ff @(posedge I_SYS_CLK)
  begin
    if (!I_RSTN)
      rd_byte_q <= 8'h00;
    else if (fetch_ev)
      rd_byte_q <= rd_sel;
  end

  // ************************************************************
  // Measurement and interrupt pin
  // ************************************************************
  assign meas.power_on  = power_on;
  assign meas.time_code = integ_q[2:0];
  assign meas.test_sel  = power_q[1:0];
  assign meas.clear     = soft_rst;
  assign meas.level     = I_LIGHT_LEVEL;

  light_meter #(.BASE_CYC(P_INTEG_BASE_CYC)) u_meter (
    .i_clk  (I_SYS_CLK),
    .i_rstn (I_RSTN),
    .m      (meas)
  );

  // Open drain: pulling low is the only drive; released reads high
  assign above    = meas.count > threshold;
  assign int_oe_d = power_on && ((isel_q == light_pkg::ISEL_LH && !above)
                                 || (isel_q == light_pkg::ISEL_HL && above));

  always_ff @(posedge I_SYS_CLK)
  begin
    if (!I_RSTN)
    begin
      int_oe_q   <= 1'b0;
      power_on_q <= 1'b0;
    end
    else
    begin
      int_oe_q   <= int_oe_d;
      power_on_q <= power_on;
    end
  end

  assign O_SDA_O    = 1'b0;
  assign O_SDA_OE   = sda_oe_q;
  assign O_INT_O    = 1'b0;
  assign O_INT_OE   = int_oe_q;
  assign O_POWER_ON = power_on_q;

  // ************************************************************
  // Checks
  // ************************************************************
  property p_pd_release;
    @(posedge I_SYS_CLK) disable iff (!I_RSTN)
    !power_on |=> !int_oe_q;
  endproperty
  a_pd_release: assert property (p_pd_release)
    else $error("Interrupt pin driven in power-down");

  property p_int_rise;
    @(posedge I_SYS_CLK) disable iff (!I_RSTN)
    (power_on && isel_q == light_pkg::ISEL_LH) |=> (int_oe_q == !$past(above));
  endproperty
  a_int_rise: assert property (p_int_rise)
    else $error("Low-to-high interrupt does not follow the threshold");

  property p_int_fall;
    @(posedge I_SYS_CLK) disable iff (!I_RSTN)
    (power_on && isel_q == light_pkg::ISEL_HL && above) |=> int_oe_q;
  endproperty
  a_int_fall: assert property (p_int_fall)
    else $error("High-to-low interrupt not pulled low above threshold");

  property p_power_write;
    @(posedge I_SYS_CLK) disable iff (!I_RSTN)
    (wr_ev && wr_addr_q == light_pkg::ADDR_POWER && wr_data_q == light_pkg::POWER_ON)
      |=> power_q == light_pkg::POWER_ON ##1 O_POWER_ON;
  endproperty
  a_power_write: assert property (p_power_write)
    else $error("Power-on write did not take effect");

  property p_bad_sel;
    @(posedge I_SYS_CLK) disable iff (!I_RSTN)
    (wr_ev && wr_addr_q == light_pkg::ADDR_ISEL && (wr_data_q == 8'h00 || wr_data_q > 8'h03))
      |=> isel_q == light_pkg::ISEL_DEF;
  endproperty
  a_bad_sel: assert property (p_bad_sel)
    else $error("Undefined interrupt select code was stored");

  property p_ro_keep;
    @(posedge I_SYS_CLK) disable iff (!I_RSTN)
    (wr_ev && wr_addr_q >= light_pkg::ADDR_COUNT_LO && !soft_rst)
      |=> ($stable(meas.count) || meas.done);
  endproperty
  a_ro_keep: assert property (p_ro_keep)
    else $error("Write altered a read-only register");

  property p_soft_reset;
    @(posedge I_SYS_CLK) disable iff (!I_RSTN)
    soft_rst |=> (reset_q == light_pkg::RESET_DEF && meas.count == 16'h0000 && $stable(power_q));
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("Reset command did not clear the count");

  property p_foreign;
    @(posedge I_SCL) disable iff (link_clr_q)
    state_q == light_pkg::LS_IDLE |-> !sda_oe_q;
  endproperty
  a_foreign: assert property (p_foreign)
    else $error("Data line driven while frame is ignored");

  property p_addr_ack;
    @(posedge I_SCL) disable iff (link_clr_q)
    (take_byte && state_q == light_pkg::LS_ADDR && addr_hit) |=> sda_oe_q;
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("Own address not acknowledged");

  property p_ptr_step;
    @(posedge I_SCL) disable iff (link_clr_q)
    wr_take |=> (ptr_q == $past(ptr_q) + 8'h01 && wr_data_q == $past(rx_byte));
  endproperty
  a_ptr_step: assert property (p_ptr_step)
    else $error("Written byte not stored or pointer not advanced");

endmodule

// ---- verif/i2c_host_model.sv ----
`timescale 1ns/1ps
module i2c_host_model
(
  input  wire logic i_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_oe
);
  initial
  begin
    o_scl = 1'h1;
    o_sda_oe = 1'h0;
  end
  // ****************
  // Bus phases
  // ****************
  // Half period of 40 system cycles leaves the crossing ample margin
  task automatic hold(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  task automatic start();
    o_sda_oe = 1'h0;
    hold(20);
    o_scl = 1'h1;
    hold(40);
    o_sda_oe = 1'h1;
    hold(40);
    o_scl = 1'h0;
  endtask
  task automatic stop();
    hold(20);
    o_sda_oe = 1'h1;
    hold(20);
    o_scl = 1'h1;
    hold(40);
    o_sda_oe = 1'h0;
    hold(40);
  endtask
  // Data moves mid-low so it never races the falling clock
  task automatic clk_bit(input logic b, output logic r);
    hold(20);
    o_sda_oe = !b;
    hold(20);
    o_scl = 1'h1;
    hold(40);
    r = i_sda;
    o_scl = 1'h0;
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      clk_bit(d[i], r);
    clk_bit(1'h1, r);
    ack = !r;
  endtask
  task automatic recv(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      clk_bit(1'h1, r);
      d[i] = r;
    end
    clk_bit(!more, r);
  endtask
endmodule

// ---- verif/tb.sv ----
`timescale 1ns/1ps
module tb;
  logic        clk = 1'h0;
  logic        rstn = 1'h0;
  logic [15:0] level = 16'h1234;
  logic        scl;
  logic        host_oe;
  logic        sda_oe;
  logic        int_oe;
  logic        pwr;
  logic        sda_o;
  logic        int_o;
  wire         sda = !(host_oe | sda_oe);
  int          err_count = 0;
  int          comparisons = 0;
  always #5 clk = ~clk;
  i2c_host_model i_host (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(host_oe));
  // Short base count: one integration is 640 cycles
  light_sensor_i2c_slave #(.P_INTEG_BASE_CYC(20)) i_dut (.I_SYS_CLK(clk), .I_RSTN(rstn),
    .I_SCL(scl), .I_SDA_I(sda), .I_LIGHT_LEVEL(level), .O_SDA_O(sda_o), .O_SDA_OE(sda_oe),
    .O_INT_O(int_o), .O_INT_OE(int_oe), .O_POWER_ON(pwr));
  // ****************
  // Helpers
  // ****************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    if (err_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input int n, input logic [31:0] d);
    logic ack;
    i_host.start();
    i_host.send(8'h72, ack);
    chk(ack, 1'h1);
    i_host.send(a, ack);
    chk(ack, 1'h1);
    for (int i = 0; i < n; i++)
    begin
      i_host.send(d[8*i +: 8], ack);
      chk(ack, 1'h1);
    end
    i_host.stop();
  endtask
  task automatic rchk(input logic [7:0] a, input int n, input logic [15:0] exp);
    logic        ack;
    logic [7:0]  b;
    logic [15:0] v;
    v = 16'h0000;
    i_host.start();
    i_host.send(8'h72, ack);
    i_host.send(a, ack);
    i_host.start();
    i_host.send(8'h73, ack);
    chk(ack, 1'h1);
    for (int i = 0; i < n; i++)
    begin
      i_host.recv(i < n - 1, b);
      v[8*i +: 8] = b;
    end
    i_host.stop();
    chk(v, exp);
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic t_defaults();
    chk(pwr, 1'h1);
    chk(int_oe, 1'h0);
    chk({sda_o, int_o}, 2'h0);
    rchk(8'h00, 2, 16'h0008);
    rchk(8'h04, 2, 16'h0800);
  endtask
  task automatic t_write();
    wr(8'h02, 2, 32'h0107);
    rchk(8'h02, 2, 16'h0107);
    wr(8'h02, 4, 32'h1000ff55);
    rchk(8'h02, 2, 16'h0302);
    rchk(8'h04, 2, 16'h1000);
  endtask
  task automatic t_foreign();
    logic ack;
    i_host.start();
    i_host.send(8'h74, ack);
    chk(ack, 1'h0);
    i_host.send(8'h00, ack);
    i_host.send(8'h00, ack);
    i_host.stop();
    chk(pwr, 1'h1);
  endtask
  task automatic t_readonly();
    wr(8'h08, 2, 32'h0000);
    rchk(8'h08, 2, light_pkg::DEVICE_ID_DEF);
    rchk(8'h06, 2, 16'h1234);
    level = 16'h0100;
    rchk(8'h06, 2, 16'h0100);
  endtask
  // Each write outlasts several integrations, so the count has settled
  task automatic t_int();
    for (int k = 0; k < 2; k++)
    begin
      level = k ? 16'h1234 : 16'h0100;
      for (int c = 1; c < 4; c++)
      begin
        wr(8'h03, 1, c);
        repeat (10) @(negedge clk);
        chk(int_oe, (c == 1 && k == 0) || (c == 2 && k == 1));
      end
    end
  endtask
  task automatic t_power();
    wr(8'h03, 1, 32'h02);
    chk(int_oe, 1'h1);
    wr(8'h00, 1, 32'h00);
    chk(pwr, 1'h0);
    chk(int_oe, 1'h0);
    level = 16'h0100;
    rchk(8'h06, 2, 16'h1234);
    rchk(8'h03, 1, 16'h0002);
  endtask
  // Run while powered down, so no new count can hide the clear
  task automatic t_reset();
    wr(8'h01, 1, 32'h10);
    rchk(8'h06, 2, 16'h0000);
    rchk(8'h01, 1, 16'h0000);
    rchk(8'h04, 2, 16'h1000);
    wr(8'h00, 1, 32'h0b);
    chk(pwr, 1'h1);
    // Level is below threshold, so only the fixed test count can pull the pin
    repeat (700) @(negedge clk);
    chk(int_oe, 1'h1);
    wr(8'h00, 1, 32'h0a);
    rchk(8'h06, 2, 16'h5555);
    wr(8'h00, 1, 32'h08);
    chk(pwr, 1'h1);
  endtask
  initial
  begin
    repeat (12) @(negedge clk);
    rstn = 1'h1;
    repeat (10) @(negedge clk);
    t_defaults();
    t_write();
    t_foreign();
    t_readonly();
    t_int();
    t_power();
    t_reset();
    wrap_up();
  end
  initial
  begin
    #1000000;
    err_count++;
    wrap_up();
  end
endmodule
